// ---- nvp_pkg.sv ----
package nvp_pkg;
  // Clock and timing
  localparam int CLK_HZ = 25_000_000;
  localparam int EE_WRITE_MS = 20;
  localparam int EE_WRITE_CYCLES = EE_WRITE_MS * (CLK_HZ / 1000);
  localparam int EE_CNT_W = 20;

  // Array geometry
  localparam int FLASH_BLOCK_BYTES = 256;
  localparam int FLASH_EXTRA_BYTES = 32;
  localparam int FLASH_ROWS = 256;
  localparam int EE_ROWS = 128;
  localparam int EE_ROW_BYTES = 16;
  localparam int EE_ROW_BITS = EE_ROW_BYTES * 8;

  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_LATCH0 = 4'h0;
  localparam logic [3:0] IDX_LATCH1 = 4'h1;
  localparam logic [3:0] IDX_LATCH2 = 4'h2;
  localparam logic [3:0] IDX_LATCH3 = 4'h3;
  localparam logic [3:0] IDX_CTRL = 4'h4;
  localparam logic [3:0] IDX_PROT = 4'h5;
  localparam logic [3:0] IDX_STATUS = 4'h6;
  localparam logic [3:0] IDX_EE_ROW = 4'h7;
  localparam logic [3:0] IDX_EE_DATA = 4'h8;
  localparam logic [3:0] IDX_EE_CMD = 4'h9;
  localparam logic [3:0] IDX_LAST = 4'h9;

  // Control register bits
  localparam int CTRL_ERASE_ALL = 0;
  localparam int CTRL_CLOSE = 1;
  localparam int CTRL_SECURE = 2;
  localparam int CTRL_CLR_REFUSED = 3;
  localparam int EE_CMD_START = 0;

  // Latch field positions
  localparam int L2_RESET_PIN = 7;
  localparam int L2_DBG_EN = 6;
  localparam int L2_PORT15 = 4;
  localparam int L3_PHASE = 4;
  localparam int L3_ECC = 3;
  localparam int L3_DPS = 0;

  // Factory latch values
  localparam logic [7:0] LATCH0_RESET = 8'h00;
  localparam logic [7:0] LATCH1_RESET = 8'h00;
  localparam logic [7:0] LATCH2_RESET = 8'h40;
  localparam logic [7:0] LATCH3_RESET = 8'h09;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    PROT_NONE = 2'b00,
    PROT_FACTORY = 2'b01,
    PROT_FIELD = 2'b10,
    PROT_FULL = 2'b11
  } nvp_prot_t;

  typedef enum logic [1:0] {
    DPS_JTAG5 = 2'b00,
    DPS_JTAG4 = 2'b01,
    DPS_SWD = 2'b10,
    DPS_OFF = 2'b11
  } nvp_dps_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic ecc_area;
    logic [7:0] row;
  } nvp_req_t;

  typedef struct packed {
    logic ack;
    logic granted;
    logic [7:0] rdata;
  } nvp_rsp_t;

  typedef struct packed {
    logic valid;
    logic fetch;
    logic [10:0] addr;
  } nvp_ee_req_t;

  typedef struct packed {
    logic [3:0] phase_delay;
    logic ecc_region_enable;
    nvp_dps_t debug_port_select;
    logic debug_access_enable;
    logic reset_pin_select;
    logic [17:0] port_reset_drive_mode;
  } nvp_cfg_t;
endpackage

// ---- nvp_access.sv ----
`timescale 1ns/1ns
// Functional notes
// - Flash blocks hold 256 data bytes plus 32 extra bytes, 256 blocks.
// - Each flash row has its own level out of four, checked per access.
// - Row levels change only after a full flash erase.
// - Unprotected rows allow every read and write.
// - Factory-upgrade rows block only external reads.
// - Field-upgrade rows block all external access.
// - Full-protection rows allow only internal reads.
// - Device security disables debug and programming ports forever.
// - EEPROM bytes are read directly at random.
// - Flash accesses continue while an EEPROM write runs.
// - EEPROM has 128 rows of 16 bytes, written as whole rows.
// - Fresh EEPROM bytes read as zero.
// - No fetches from EEPROM and no EEPROM error correction.
// - Writes take up to 20 ms; avoid reset meanwhile.
// - Four configuration latch bytes configure the device at reset.
// - Two-bit port reset drive mode per port.
// - Reset pin select: 0 general I/O, 1 external reset.
// - Debug access enable: 1 allows, 0 denies external debug.
// - Debug port select: JTAG5, JTAG4, SWD, none.
// - ECC enable reserves the extra flash area for codes.
// - Four-bit digital clock phase delay field.
// - With ECC on, correct single and detect double errors per 8 bytes.
module nvp_access #(
  parameter int EE_WRITE_TIME = nvp_pkg::EE_WRITE_CYCLES,
  parameter logic RESET_PIN_DEFAULT = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire nvp_pkg::nvp_req_t ext_req,
  output nvp_pkg::nvp_rsp_t ext_rsp,
  input wire logic [7:0] flash_ext_rdata,
  input wire nvp_pkg::nvp_req_t cpu_req,
  output nvp_pkg::nvp_rsp_t cpu_rsp,
  input wire logic [7:0] flash_cpu_rdata,
  input wire nvp_pkg::nvp_ee_req_t ee_req,
  output nvp_pkg::nvp_rsp_t ee_rsp,
  output nvp_pkg::nvp_cfg_t cfg,
  output logic ext_port_enable,
  output logic ecc_correct_enable,
  output logic nv_write_busy
);
  import nvp_pkg::*;

  typedef enum logic {ER_IDLE, ER_WALK} nvp_er_t;
  typedef enum logic [1:0] {EE_IDLE, EE_WAIT, EE_COMMIT} nvp_ee_t;

  // Protection check for one access
  function automatic logic prot_allows(input nvp_prot_t lvl, input logic ext,
                                       input logic wr);
    case (lvl)
      PROT_NONE: prot_allows = 1'b1;
      PROT_FACTORY: prot_allows = !(ext && !wr);
      PROT_FIELD: prot_allows = !ext;
      PROT_FULL: prot_allows = !ext && !wr;
      default: prot_allows = 1'b0;
    endcase
  endfunction

  // Register index of a byte address, valid flag in the top bit
  function automatic logic [4:0] reg_decode(input logic [7:0] addr);
    logic [3:0] idx;
    idx = addr[5:2];
    reg_decode = {addr[7:6] == 2'b00 && addr[1:0] == 2'b00 && idx <= IDX_LAST, idx};
  endfunction

  // Nonvolatile stores, factory contents
  logic [7:0] latch [0:3] = '{LATCH0_RESET, LATCH1_RESET,
                              LATCH2_RESET | {RESET_PIN_DEFAULT, 7'h00}, LATCH3_RESET};
  logic [7:0] next_latch [0:3];
  logic [1:0] prot_lvl [0:FLASH_ROWS-1] = '{default: PROT_NONE};
  logic [EE_ROW_BITS-1:0] ee_mem [0:EE_ROWS-1] = '{default: '0};
  logic secure = 1'b0;
  logic next_secure;

  // Bus state
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic wr_fire;
  logic [4:0] wr_dec, rd_dec;

  // Control state
  nvp_er_t er_state, next_er_state;
  nvp_ee_t ee_state, next_ee_state;
  logic [7:0] er_cnt, next_er_cnt;
  logic window_open, next_window_open;
  logic refused, next_refused;
  logic [7:0] prot_row, next_prot_row;
  logic [EE_CNT_W-1:0] ee_cnt, next_ee_cnt;
  logic [6:0] ee_row, next_ee_row;
  logic [6:0] ee_tgt, next_ee_tgt;
  logic [EE_ROW_BITS-1:0] ee_buf, next_ee_buf;
  logic next_ext_port_enable, next_busy;
  nvp_rsp_t next_ext_rsp, next_cpu_rsp, next_ee_rsp;
  logic prot_we;
  logic [7:0] prot_waddr;
  logic [1:0] prot_wdata;
  logic ee_we;
  logic [EE_ROW_BITS-1:0] ee_row_data;
  logic ext_ok, cpu_ok;

  // Bus handshakes, taken one at a time
  assign awready = !aw_held;
  assign wready = !w_held;
  assign arready = !rvalid;
  assign wr_fire = aw_held && w_held && !bvalid;
  assign wr_dec = reg_decode(aw_addr);
  assign rd_dec = reg_decode(araddr);

  // Bus next values
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_dec[4] ? RESP_OKAY : RESP_SLVERR;
    end
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp = rd_dec[4] ? RESP_OKAY : RESP_SLVERR;
      next_rdata = 32'h0000_0000;
      if (rd_dec[4]) begin
        case (rd_dec[3:0])
          IDX_LATCH0, IDX_LATCH1, IDX_LATCH2, IDX_LATCH3:
            next_rdata = {24'h00_0000, latch[rd_dec[1:0]]};
          IDX_PROT: next_rdata = {22'h00_0000, prot_lvl[prot_row], prot_row};
          IDX_STATUS: next_rdata = {27'h000_0000, refused, nv_write_busy,
                                    er_state == ER_WALK, window_open, secure};
          IDX_EE_ROW: next_rdata = {25'h000_0000, ee_row};
          default: next_rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // Bus registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= 32'h0000_0000;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  // Access checks for the programmer side and the CPU side
  assign ext_ok = ext_req.valid && ext_port_enable && er_state == ER_IDLE
                  && !(ext_req.ecc_area && cfg.ecc_region_enable)
                  && prot_allows(nvp_prot_t'(prot_lvl[ext_req.row]), 1'b1,
                                 ext_req.write);
  assign cpu_ok = cpu_req.valid && er_state == ER_IDLE
                  && !(cpu_req.ecc_area && cfg.ecc_region_enable)
                  && prot_allows(nvp_prot_t'(prot_lvl[cpu_req.row]), 1'b0,
                                 cpu_req.write);

  // Control next values: latches, protection, erase walk, EEPROM writer
  always_comb begin
    next_latch = latch;
    next_secure = secure;
    next_er_state = er_state;
    next_er_cnt = er_cnt;
    next_window_open = window_open;
    next_refused = refused;
    next_prot_row = prot_row;
    next_ee_state = ee_state;
    next_ee_cnt = ee_cnt;
    next_ee_row = ee_row;
    next_ee_tgt = ee_tgt;
    next_ee_buf = ee_buf;
    prot_we = 1'b0;
    prot_waddr = er_cnt;
    prot_wdata = PROT_NONE;
    ee_we = 1'b0;
    ee_row_data = ee_buf;
    if (wr_fire && wr_dec[4]) begin
      if (wr_dec[3:2] == 2'b00) begin
        if (w_strb[0]) begin
          next_latch[wr_dec[1:0]] = w_data[7:0];
        end
      end else if (w_strb[1:0] == 2'b11) begin
        case (wr_dec[3:0])
          IDX_CTRL: begin
            if (w_data[CTRL_ERASE_ALL] && er_state == ER_IDLE) begin
              next_er_state = ER_WALK;
              next_er_cnt = 8'h00;
              next_window_open = 1'b0;
            end
            if (w_data[CTRL_CLOSE]) begin
              next_window_open = 1'b0;
            end
            if (w_data[CTRL_SECURE]) begin
              next_secure = 1'b1;
            end
            if (w_data[CTRL_CLR_REFUSED]) begin
              next_refused = 1'b0;
            end
          end
          IDX_PROT: begin
            next_prot_row = w_data[7:0];
            if (window_open && er_state == ER_IDLE) begin
              prot_we = 1'b1;
              prot_waddr = w_data[7:0];
              prot_wdata = w_data[9:8];
            end else begin
              next_refused = 1'b1;
            end
          end
          IDX_EE_ROW: next_ee_row = w_data[6:0];
          IDX_EE_DATA: begin
            if (ee_state == EE_IDLE) begin
              next_ee_buf[w_data[11:8]*8 +: 8] = w_data[7:0];
            end else begin
              next_refused = 1'b1;
            end
          end
          IDX_EE_CMD: begin
            if (w_data[EE_CMD_START] && ee_state == EE_IDLE) begin
              next_ee_state = EE_WAIT;
              next_ee_tgt = ee_row;
              next_ee_cnt = '0;
            end else if (w_data[EE_CMD_START]) begin
              next_refused = 1'b1;
            end
          end
          default: next_refused = refused;
        endcase
      end
    end
    // Full erase clears every row level, then opens the level window
    case (er_state)
      ER_WALK: begin
        prot_we = 1'b1;
        prot_waddr = er_cnt;
        prot_wdata = PROT_NONE;
        next_er_cnt = er_cnt + 8'h01;
        if (er_cnt == 8'(FLASH_ROWS - 1)) begin
          next_er_state = ER_IDLE;
          next_window_open = 1'b1;
        end
      end
      default: next_er_state = next_er_state;
    endcase
    // EEPROM row write runs for the full write time, then commits the row
    case (ee_state)
      EE_WAIT: begin
        next_ee_cnt = ee_cnt + 1'b1;
        if (ee_cnt == EE_CNT_W'(EE_WRITE_TIME - 2)) begin
          next_ee_state = EE_COMMIT;
        end
      end
      EE_COMMIT: begin
        ee_we = 1'b1;
        ee_row_data = ee_buf;
        next_ee_buf = '0;
        next_ee_state = EE_IDLE;
      end
      default: next_ee_state = next_ee_state;
    endcase
    next_ext_port_enable = !next_secure && cfg.debug_access_enable
                           && cfg.debug_port_select != DPS_OFF;
    next_busy = next_ee_state != EE_IDLE || next_er_state == ER_WALK;
    next_ext_rsp.ack = ext_req.valid;
    next_ext_rsp.granted = ext_ok;
    next_ext_rsp.rdata = (ext_ok && !ext_req.write) ? flash_ext_rdata : 8'h00;
    next_cpu_rsp.ack = cpu_req.valid;
    next_cpu_rsp.granted = cpu_ok;
    next_cpu_rsp.rdata = (cpu_ok && !cpu_req.write) ? flash_cpu_rdata : 8'h00;
    next_ee_rsp.ack = ee_req.valid;
    next_ee_rsp.granted = ee_req.valid && !ee_req.fetch;
    next_ee_rsp.rdata = (ee_req.valid && !ee_req.fetch)
                        ? ee_mem[ee_req.addr[10:4]][ee_req.addr[3:0]*8 +: 8]
                        : 8'h00;
  end

  // Nonvolatile stores keep their contents across reset
  always_ff @(posedge aclk) begin
    latch <= next_latch;
    secure <= next_secure;
    if (prot_we) begin
      prot_lvl[prot_waddr] <= prot_wdata;
    end
    if (ee_we) begin
      ee_mem[ee_tgt] <= ee_row_data;
    end
  end

  // Applied configuration, caught while reset is held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg.port_reset_drive_mode <= {latch[2][L2_PORT15 +: 2], latch[1], latch[0]};
      cfg.reset_pin_select <= latch[2][L2_RESET_PIN];
      cfg.debug_access_enable <= latch[2][L2_DBG_EN];
      cfg.debug_port_select <= nvp_dps_t'(latch[3][L3_DPS +: 2]);
      cfg.ecc_region_enable <= latch[3][L3_ECC];
      cfg.phase_delay <= latch[3][L3_PHASE +: 4];
    end else begin
      cfg <= cfg;
    end
  end

  // Control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      er_state <= ER_IDLE;
      er_cnt <= 8'h00;
      window_open <= 1'b0;
      refused <= 1'b0;
      prot_row <= 8'h00;
      ee_state <= EE_IDLE;
      ee_cnt <= '0;
      ee_row <= 7'h00;
      ee_tgt <= 7'h00;
      ee_buf <= '0;
      ext_port_enable <= 1'b0;
      ecc_correct_enable <= 1'b0;
      nv_write_busy <= 1'b0;
      ext_rsp <= '0;
      cpu_rsp <= '0;
      ee_rsp <= '0;
    end else begin
      er_state <= next_er_state;
      er_cnt <= next_er_cnt;
      window_open <= next_window_open;
      refused <= next_refused;
      prot_row <= next_prot_row;
      ee_state <= next_ee_state;
      ee_cnt <= next_ee_cnt;
      ee_row <= next_ee_row;
      ee_tgt <= next_ee_tgt;
      ee_buf <= next_ee_buf;
      ext_port_enable <= next_ext_port_enable;
      ecc_correct_enable <= cfg.ecc_region_enable;
      nv_write_busy <= next_busy;
      ext_rsp <= next_ext_rsp;
      cpu_rsp <= next_cpu_rsp;
      ee_rsp <= next_ee_rsp;
    end
  end
endmodule

// ---- nvp_access_props.sv ----
`timescale 1ns/1ns
module nvp_access_props
  import nvp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire nvp_pkg::nvp_req_t ext_req,
  input wire nvp_pkg::nvp_rsp_t ext_rsp,
  input wire nvp_pkg::nvp_req_t cpu_req,
  input wire nvp_pkg::nvp_rsp_t cpu_rsp,
  input wire nvp_pkg::nvp_ee_req_t ee_req,
  input wire nvp_pkg::nvp_rsp_t ee_rsp,
  input wire nvp_pkg::nvp_cfg_t cfg,
  input wire logic ext_port_enable,
  input wire logic ecc_correct_enable,
  input wire logic nv_write_busy
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Access answers, gating and held configuration
  a_ext_ack_next: assert property (ext_req.valid |=> ext_rsp.ack)
    else $error("programmer request not answered");
  a_ext_no_data: assert property (ext_rsp.ack && !ext_rsp.granted |-> ext_rsp.rdata == 8'h00)
    else $error("blocked programmer access returned data");
  a_cpu_no_data: assert property (cpu_rsp.ack && !cpu_rsp.granted |-> cpu_rsp.rdata == 8'h00)
    else $error("blocked cpu access returned data");
  a_ee_no_fetch: assert property (ee_req.valid && ee_req.fetch |=>
    ee_rsp.ack && !ee_rsp.granted && ee_rsp.rdata == 8'h00)
    else $error("fetch from eeprom was served");
  a_ee_read_direct: assert property (ee_req.valid && !ee_req.fetch |=> ee_rsp.ack && ee_rsp.granted)
    else $error("eeprom byte read not served");
  a_cfg_held: assert property ($past(aresetn) |-> $stable(cfg))
    else $error("applied configuration changed outside reset");
  a_port_gate: assert property ($past(aresetn, 2) && ext_port_enable |->
    cfg.debug_access_enable && cfg.debug_port_select != DPS_OFF)
    else $error("external port enabled against configuration");
  a_ext_locked: assert property ($past(aresetn, 2) && !ext_port_enable && ext_req.valid |=>
    ext_rsp.ack && !ext_rsp.granted)
    else $error("programmer access granted while ports closed");
  a_ecc_follow: assert property ($past(aresetn) |-> ecc_correct_enable == $past(cfg.ecc_region_enable))
    else $error("ecc enable does not follow configuration");

  // Main scenarios
  c_ext_blocked: cover property (ext_req.valid ##1 !ext_rsp.granted);
  c_cpu_busy: cover property (nv_write_busy && cpu_req.valid);
  c_ee_fetch: cover property (ee_req.valid && ee_req.fetch);
endmodule

bind nvp_access nvp_access_props u_nvp_access_props (.aclk, .aresetn, .ext_req, .ext_rsp, .cpu_req,
  .cpu_rsp, .ee_req, .ee_rsp, .cfg, .ext_port_enable, .ecc_correct_enable, .nv_write_busy);

// ---- nvp_flash_model.sv ----
`timescale 1ns/1ns
module nvp_flash_model
  import nvp_pkg::*;
(
  input wire logic aclk,
  input wire nvp_pkg::nvp_req_t ext_req,
  input wire nvp_pkg::nvp_req_t cpu_req,
  output logic [7:0] ext_rdata,
  output logic [7:0] cpu_rdata
);
  logic [7:0] mem [FLASH_ROWS];
  logic [7:0] last_ext = 8'h00;
  logic [7:0] last_cpu = 8'h00;
  // One sample byte per row
  initial for (int i = 0; i < FLASH_ROWS; i++) mem[i] = 8'(i) ^ 8'h5a;
  // Row byte while requested, a toggling pattern otherwise
  always_comb begin
    ext_rdata = ext_req.valid ? mem[ext_req.row] : ~last_ext;
    cpu_rdata = cpu_req.valid ? mem[cpu_req.row] : ~last_cpu;
  end
  // Remember the last driven bytes
  always_ff @(posedge aclk) begin
    last_ext <= ext_rdata;
    last_cpu <= cpu_rdata;
  end
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ns
module testbench;
  import nvp_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, ext_port_enable, ecc_correct_enable;
  logic nv_write_busy;
  logic [7:0] awaddr = '0, araddr = '0, flash_ext_rdata, flash_cpu_rdata;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = '0;
  logic [1:0] bresp, rresp;
  nvp_req_t ext_req = '0, cpu_req = '0;
  nvp_ee_req_t ee_req = '0;
  nvp_rsp_t ext_rsp, cpu_rsp, ee_rsp;
  nvp_cfg_t cfg;
  int n_errors = 0, compares = 0;

  always #20 aclk = ~aclk;

  nvp_access #(.EE_WRITE_TIME(40)) u_nvp_access (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .ext_req, .ext_rsp, .flash_ext_rdata, .cpu_req, .cpu_rsp,
    .flash_cpu_rdata, .ee_req, .ee_rsp, .cfg, .ext_port_enable, .ecc_correct_enable,
    .nv_write_busy);
  nvp_flash_model u_nvp_flash_model (.aclk, .ext_req, .cpu_req, .ext_rdata(flash_ext_rdata),
    .cpu_rdata(flash_cpu_rdata));

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic print_verdict;
    if (n_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Bounded clock step
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 2000) begin
      n_errors++;
      print_verdict;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = RESP_OKAY);
    int n;
    logic ad, wd;
    n = 0;
    ad = 0;
    wd = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      tick(n);
      if (!ad && awready === 1'b1) begin
        ad = 1;
        awvalid <= 0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1;
        wvalid <= 0;
      end
    end while (!(ad && wd));
    while (bvalid !== 1'b1) tick(n);
    chk(bresp, e);
    bready <= 0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] e = RESP_OKAY);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do tick(n); while (arready !== 1'b1);
    arvalid <= 0;
    do tick(n); while (rvalid !== 1'b1);
    d = rdata;
    chk(rresp, e);
    rready <= 0;
    @(posedge aclk);
  endtask

  task automatic acc(input logic c, w, g, input logic [7:0] row, output nvp_rsp_t r);
    if (c) cpu_req <= '{1'b1, w, g, row};
    else ext_req <= '{1'b1, w, g, row};
    @(posedge aclk);
    cpu_req <= '0;
    ext_req <= '0;
    @(posedge aclk);
    r = c ? cpu_rsp : ext_rsp;
  endtask

  task automatic ee(input logic f, input logic [10:0] a, output nvp_rsp_t r);
    ee_req <= '{1'b1, f, a};
    @(posedge aclk);
    ee_req <= '0;
    @(posedge aclk);
    r = ee_rsp;
  endtask

  task automatic idle;
    int n;
    n = 0;
    while (nv_write_busy !== 1'b0) tick(n);
  endtask

  task automatic rst;
    if (aresetn) idle;
    aresetn <= 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
  endtask

  function automatic nvp_cfg_t xcfg(input logic [7:0] l [4]);
    return '{l[3][7:4], l[3][3], nvp_dps_t'(l[3][1:0]), l[2][6], l[2][7], {l[2][5:4], l[1], l[0]}};
  endfunction

  function automatic logic ok(input logic [1:0] v, input logic x, w);
    case (v)
      2'd0: return 1'b1;
      2'd1: return !(x && !w);
      2'd2: return !x;
      default: return !x && !w;
    endcase
  endfunction

  // Hang guard
  initial begin
    repeat (60000) @(posedge aclk);
    n_errors++;
    print_verdict;
  end

  // Main sequence
  initial begin
    logic [31:0] d;
    nvp_rsp_t r;
    nvp_cfg_t c0;
    logic [7:0] l [4];
    logic [7:0] rows [4];
    logic [7:0] eb [16];
    logic [6:0] er;
    logic en;
    void'($urandom(63440));
    rst;
    l = '{8'h00, 8'h00, 8'h40, 8'h09};
    for (int i = 0; i < 4; i++) begin
      rd(8'(4 * i), d);
      chk(d, {24'h0, l[i]});
    end
    chk(cfg, xcfg(l));
    for (int k = 0; k < 5; k++) begin
      for (int i = 0; i < 4; i++) l[i] = 8'($urandom);
      l[3][1:0] = 2'(k);
      l[2][6] = (k != 4);
      c0 = cfg;
      for (int i = 0; i < 4; i++) wr(8'(4 * i), {24'h0, l[i]});
      chk(cfg, c0);
      rst;
      chk(cfg, xcfg(l));
      chk(ecc_correct_enable, l[3][3]);
      en = l[2][6] && (l[3][1:0] != 2'b11);
      chk(ext_port_enable, en);
      acc(0, 0, 0, 8'h01, r);
      chk(r.granted, en);
      acc(0, 0, 1, 8'h02, r);
      chk(r.granted, en && !l[3][3]);
    end
    l = '{8'h00, 8'h00, 8'h40, 8'h09};
    for (int i = 0; i < 4; i++) wr(8'(4 * i), {24'h0, l[i]});
    rst;
    wr(8'h40, 32'h0, RESP_SLVERR);
    rd(8'h40, d, RESP_SLVERR);
    chk(d, 32'h0);
    rd(8'h02, d, RESP_SLVERR);
    // Row write through the command registers, refused data while busy
    er = 7'($urandom);
    ee(0, {er, 4'h7}, r);
    chk(r.rdata, 8'h00);
    wr(8'h1c, {25'h0, er});
    for (int b = 0; b < 15; b++) begin
      eb[b] = 8'($urandom);
      wr(8'h20, {20'h0, 4'(b), eb[b]});
    end
    eb[15] = 8'h00;
    wr(8'h24, 32'h1);
    chk(nv_write_busy, 1'b1);
    acc(1, 0, 0, 8'h05, r);
    chk(r.granted, 1'b1);
    wr(8'h20, 32'h0fff);
    rd(8'h18, d);
    chk(d[4:3], 2'b11);
    idle;
    for (int b = 0; b < 16; b++) begin
      ee(0, {er, 4'(b)}, r);
      chk(r.rdata, eb[b]);
    end
    ee(1, {er, 4'h0}, r);
    chk({r.granted, r.rdata}, 9'h0);
    // Erase opens the level window, closing it freezes the levels
    wr(8'h10, 32'h8);
    wr(8'h10, 32'h1);
    idle;
    rd(8'h18, d);
    chk(d[4:1], 4'b0001);
    for (int v = 0; v < 4; v++) begin
      rows[v] = 8'(16 * v + $urandom_range(15, 0));
      wr(8'h14, {22'h0, 2'(v), rows[v]});
      rd(8'h14, d);
      chk(d[9:0], {2'(v), rows[v]});
    end
    wr(8'h10, 32'h2);
    wr(8'h14, {22'h0, 2'b11, rows[0]});
    rd(8'h14, d);
    chk(d[9:0], {2'b00, rows[0]});
    rd(8'h18, d);
    chk(d[4], 1'b1);
    for (int v = 0; v < 4; v++) for (int k = 0; k < 4; k++) begin
      en = ok(2'(v), !k[1], k[0]);
      acc(k[1], k[0], 0, rows[v], r);
      chk(r.granted, en);
      chk(r.ack, 1'b1);
      if (!k[0]) chk(r.rdata, en ? (rows[v] ^ 8'h5a) : 8'h00);
    end
    // Device security survives reset
    wr(8'h10, 32'h4);
    rst;
    chk(ext_port_enable, 1'b0);
    acc(0, 0, 0, rows[0], r);
    chk(r.granted, 1'b0);
    print_verdict;
  end
endmodule
